//--- hdl/fpx_pkg.sv
// Shared constants and rounding helpers for the SIMD FP underflow/inexact unit
package fpx_pkg;
    localparam int NL = 2;
    localparam int LW = 64;
    localparam int EW = 16;
    localparam int NF = 6;
    // Register byte offsets
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_STAT = 8'h04;
    localparam logic [7:0] A_IREN = 8'h08;
    localparam logic [7:0] A_TRAP = 8'h0c;
    // Flag positions, common to status, masks, enables and causes
    localparam int F_IE = 0;
    localparam int F_DE = 1;
    localparam int F_ZE = 2;
    localparam int F_OE = 3;
    localparam int F_UE = 4;
    localparam int F_PE = 5;
    // Control register fields
    localparam int C_MSK = 0;
    localparam int C_RC = 6;
    localparam int C_DAZ = 8;
    localparam int C_FTZ = 9;
    localparam int CW = 10;
    localparam logic [CW-1:0] CTRL_RST = 10'h03f;
    localparam logic [NF-1:0] STAT_RST = 6'h00;
    localparam logic [NF-1:0] IREN_RST = 6'h00;
    // Rounding modes
    localparam logic [1:0] RC_NEAR = 2'h0;
    localparam logic [1:0] RC_DOWN = 2'h1;
    localparam logic [1:0] RC_UP = 2'h2;
    localparam logic [1:0] RC_ZERO = 2'h3;
    // Format figures
    localparam int P_SP = 24;
    localparam int P_DP = 53;
    localparam logic signed [EW-1:0] EMIN_SP = -16'sh007e;
    localparam logic signed [EW-1:0] EMAX_SP = 16'sh007f;
    localparam logic signed [EW-1:0] EMIN_DP = -16'sh03fe;
    localparam logic signed [EW-1:0] EMAX_DP = 16'sh03ff;
    localparam logic signed [EW-1:0] BIAS_SP = 16'sh007f;
    localparam logic signed [EW-1:0] BIAS_DP = 16'sh03ff;
    localparam logic signed [EW-1:0] SCL_SP = 16'sh00c0;
    localparam logic signed [EW-1:0] SCL_DP = 16'sh0600;

    // Round a left-aligned significand to n bits; returns {inexact, value}
    function automatic logic [54:0] rnd_f(input logic [63:0] m, input int n,
        input logic [1:0] rc, input logic sgn);
        logic [63:0] rem;
        logic [63:0] half;
        logic [63:0] kept;
        logic inc;
        logic inx;
        int sh;
        sh = 64 - n;
        kept = m >> sh;
        rem = m & ((64'h1 << sh) - 64'h1);
        half = 64'h1 << (sh - 1);
        inx = rem != 64'h0;
        case (rc)
            RC_NEAR: inc = (rem > half) || (rem == half && kept[0]);
            RC_DOWN: inc = sgn && inx;
            RC_UP: inc = !sgn && inx;
            default: inc = 1'b0;
        endcase
        return {inx, kept[53:0] + {53'h0, inc}};
    endfunction

    // Pack sign, biased exponent field and rounded significand
    function automatic logic [63:0] pack_f(input logic dbl, input logic sgn,
        input logic [10:0] ef, input logic [54:0] r);
        if (dbl) begin
            return {sgn, ef, r[51:0]};
        end
        return {32'h0, sgn, ef[7:0], r[22:0]};
    endfunction
endpackage

//--- hdl/fpx_daz.sv
// Denormals-as-zero operand cleaner for one lane
`timescale 1ns/1ps
module fpx_daz
    import fpx_pkg::*;
(
    input wire logic dbl,
    input wire logic daz,
    input wire logic [LW-1:0] din,
    output logic [LW-1:0] dout
);
    logic dnrm;

    // Denormal: zero exponent field with non-zero fraction
    always_comb begin
        if (dbl) begin
            dnrm = din[62:52] == 11'h000 && din[51:0] != 52'h0;
        end else begin
            dnrm = din[30:23] == 8'h00 && din[22:0] != 23'h0;
        end
        dout = din;
        if (daz && dnrm) begin
            dout = dbl ? {din[63], 63'h0} : {din[63:32], din[31], 31'h0};
        end
    end
endmodule

//--- hdl/fpx_elem.sv
// Per-element post-computation exception logic and result delivery
`timescale 1ns/1ps
module fpx_elem
    import fpx_pkg::*;
(
    input wire logic dbl,
    input wire logic [1:0] rc,
    input wire logic ftz,
    input wire logic [NF-1:0] mask,
    input wire logic sgn,
    input wire logic signed [EW-1:0] uexp,
    input wire logic [LW-1:0] mant,
    input wire logic zero,
    input wire logic [2:0] pre,
    output logic [LW-1:0] y,
    output logic [NF-1:0] fl,
    output logic trp
);
    logic [54:0] r1;
    logic [54:0] r53;
    logic [54:0] rd;
    logic [63:0] ms;
    logic [63:0] m2;
    logic signed [EW-1:0] e1;
    logic signed [EW-1:0] e2;
    logic signed [EW-1:0] emin;
    logic signed [EW-1:0] emax;
    logic signed [EW-1:0] bias;
    logic signed [EW-1:0] scl;
    logic signed [EW-1:0] d;
    logic [5:0] dsh;
    logic tiny;
    logic huge;
    logic sat;
    logic dinx;
    int p;

    // Unbounded rounding, tininess and denormal path
    always_comb begin
        p = dbl ? P_DP : P_SP;
        emin = dbl ? EMIN_DP : EMIN_SP;
        emax = dbl ? EMAX_DP : EMAX_SP;
        bias = dbl ? BIAS_DP : BIAS_SP;
        scl = dbl ? SCL_DP : SCL_SP;
        r1 = rnd_f(mant, p, rc, sgn);
        e1 = uexp + EW'(r1[p]);
        tiny = !zero && e1 < emin;
        huge = !zero && e1 > emax;
        r53 = rnd_f(mant, P_DP, rc, sgn);
        ms = dbl ? mant : (r53[53] ? 64'h8000_0000_0000_0000 : {r53[52:0], 11'h0});
        e2 = dbl ? uexp : uexp + EW'(r53[53]);
        d = emin - e2;
        dsh = (d > 16'sh003f) ? 6'h3f : d[5:0];
        m2 = (ms >> dsh) | {63'h0, |(ms & ((64'h1 << dsh) - 64'h1))};
        rd = rnd_f(m2, p, rc, sgn);
        dinx = rd[54] || (!dbl && r53[54]);
        sat = (rc == RC_ZERO) || (rc == RC_DOWN && !sgn) || (rc == RC_UP && sgn);
    end

    // Exception priority and response selection
    always_comb begin
        y = '0;
        fl = {3'h0, pre};
        trp = 1'b0;
        if (pre[F_ZE]) begin
            fl[F_DE] = 1'b0;
        end
        if (|(fl[2:0] & ~mask[2:0])) begin
            trp = 1'b1;
        end else if (zero) begin
            y = pack_f(dbl, sgn, 11'h000, 55'h0);
        end else if (huge) begin
            fl[F_OE] = 1'b1;
            if (mask[F_OE]) begin
                fl[F_PE] = 1'b1;
                trp = !mask[F_PE];
                if (sat) begin
                    y = pack_f(dbl, sgn, 11'(emax + bias), {55{1'b1}});
                end else begin
                    y = pack_f(dbl, sgn, dbl ? 11'h7ff : 11'h0ff, 55'h0);
                end
            end else begin
                fl[F_PE] = r1[54];
                trp = 1'b1;
                y = pack_f(dbl, sgn, 11'(e1 + bias - scl), r1);
            end
        end else if (tiny) begin
            if (!mask[F_UE]) begin
                fl[F_UE] = 1'b1;
                fl[F_PE] = r1[54];
                trp = 1'b1;
                y = pack_f(dbl, sgn, 11'(e1 + bias + scl), r1);
            end else if (ftz) begin
                fl[F_UE] = 1'b1;
                fl[F_PE] = 1'b1;
                trp = !mask[F_PE];
                y = pack_f(dbl, sgn, 11'h000, 55'h0);
            end else begin
                fl[F_UE] = dinx;
                fl[F_PE] = dinx;
                trp = dinx && !mask[F_PE];
                y = pack_f(dbl, sgn, {10'h0, rd[p-1]}, rd);
            end
        end else begin
            fl[F_PE] = r1[54];
            trp = r1[54] && !mask[F_PE];
            y = pack_f(dbl, sgn, 11'(e1 + bias), r1);
        end
    end
endmodule

//--- hdl/fpx_core.sv
// SIMD FP underflow/inexact exception unit with APB register slave
//
// Overview of operation
// - Single destination: tiny when unbounded rounded result is below smallest normal.
// - Masked underflow delivers zero, denormal or normal; flags only if inexact.
// - Unmasked single underflow hands over rounded result times two to 192.
// - Double destination: detect against double minimum; unmasked scale by 2^1536.
// - Inexact raised whenever result is not exactly representable.
// - Masked inexact sets flag, delivers bounded rounded result.
// - Unmasked inexact with masked overflow/underflow uses that masked result too.
// - Denormals-as-zero replaces denormal operands by signed zero, flags untouched.
// - Tiny/huge checks only after invalid, denormal, divide-by-zero pass.
// - Tiny results are shifted right until exponent is in range.
// - Denormalize single results from a 53-bit rounded value to avoid double rounding; double from the unrounded significand.
// - Unmasked inexact traps and still offers the computed result.
// - Flush-to-zero replaces tiny results by zero when enabled and underflow is masked.
// - Mask order inexact, underflow, overflow, zero-divide, denormal, invalid at bit 0.
// - Encodings 0x20, 0x10, 0x08, 0x04, 0x02, 0x01 respectively.
// - Divide by zero clears the denormal indication of that division.
//
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/1ps
module fpx_core
    import fpx_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic op_valid,
    input wire logic op_dbl,
    input wire logic [NL*LW-1:0] op_a,
    input wire logic [NL*LW-1:0] op_b,
    output logic cln_valid,
    output logic [NL*LW-1:0] cln_a,
    output logic [NL*LW-1:0] cln_b,
    input wire logic res_valid,
    input wire logic res_dbl,
    input wire logic [NL-1:0] res_lane_en,
    input wire logic [NL-1:0] res_sign,
    input wire logic [NL*EW-1:0] res_exp,
    input wire logic [NL*LW-1:0] res_mant,
    input wire logic [NL-1:0] res_zero,
    input wire logic [NL*3-1:0] res_pre,
    output logic out_valid,
    output logic [NL*LW-1:0] out_data,
    output logic [NF-1:0] out_flags,
    output logic trap,
    output logic [NF-1:0] trap_cause,
    output logic irq
);
    // One-hot register select, shared by read and write paths
    function automatic logic [3:0] dec_f(input logic [7:0] a);
        return {a == A_TRAP, a == A_IREN, a == A_STAT, a == A_CTRL};
    endfunction

    logic [1:0] rst_sync_q;
    logic rst_n;
    logic [CW-1:0] ctrl_q;
    logic [NF-1:0] status_q;
    logic [NF-1:0] iren_q;
    logic [NF-1:0] masks;
    logic [3:0] sel;
    logic lat_q;
    logic [31:0] prdata_q;
    logic wr_en;
    logic [NF-1:0] st_clr;
    logic [NL*LW-1:0] cln_a_d;
    logic [NL*LW-1:0] cln_b_d;
    logic [NL*LW-1:0] lane_y;
    logic [NL*NF-1:0] lane_fl;
    logic [NL-1:0] lane_trp;
    logic [NF-1:0] acc_fl;
    logic acc_trp;
    logic [NL*LW-1:0] acc_y;
    logic cln_valid_q;
    logic [NL*LW-1:0] cln_a_q;
    logic [NL*LW-1:0] cln_b_q;
    logic out_valid_q;
    logic [NL*LW-1:0] out_data_q;
    logic [NF-1:0] out_flags_q;
    logic trap_q;
    logic [NF-1:0] trap_cause_q;

    // Reset release through two flops; assertion stays asynchronous
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    assign masks = ctrl_q[C_MSK +: NF];

    // APB decode; no wait state, read data comes from a flop loaded in the setup phase
    assign sel = dec_f(paddr);
    assign pready = psel && penable && ce && lat_q;
    assign pslverr = pready && (sel == 4'h0);
    assign wr_en = pready && pwrite && (sel != 4'h0);
    assign prdata = prdata_q;

    // Setup phase arms the access and samples read data
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            lat_q <= 1'b0;
            prdata_q <= 32'h0;
        end else if (ce) begin
            if (psel && !penable) begin
                lat_q <= 1'b1;
                unique case (1'b1)
                    sel[0]: prdata_q <= {22'h0, ctrl_q};
                    sel[1]: prdata_q <= {26'h0, status_q};
                    sel[2]: prdata_q <= {26'h0, iren_q};
                    sel[3]: prdata_q <= {26'h0, trap_cause_q};
                    default: prdata_q <= 32'h0;
                endcase
            end else if (pready) begin
                lat_q <= 1'b0;
            end
        end
    end

    // Control and interrupt-enable registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= CTRL_RST;
            iren_q <= IREN_RST;
        end else if (ce && wr_en) begin
            if (sel[0]) begin
                ctrl_q <= pwdata[CW-1:0];
            end
            if (sel[2]) begin
                iren_q <= pwdata[NF-1:0];
            end
        end
    end

    // sticky flags, write one to clear, set beats clear
    assign st_clr = (wr_en && sel[1]) ? pwdata[NF-1:0] : '0;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            status_q <= STAT_RST;
        end else if (ce) begin
            status_q <= (status_q & ~st_clr) | (res_valid ? acc_fl : '0);
        end
    end

    // Level interrupt while an enabled flag is set
    assign irq = |(status_q & iren_q);

    // Per-lane operand cleaning and exception evaluation
    for (genvar l = 0; l < NL; l++) begin : g_lane
        fpx_daz u_daz_a (
            .dbl(op_dbl),
            .daz(ctrl_q[C_DAZ]),
            .din(op_a[l*LW +: LW]),
            .dout(cln_a_d[l*LW +: LW])
        );
        fpx_daz u_daz_b (
            .dbl(op_dbl),
            .daz(ctrl_q[C_DAZ]),
            .din(op_b[l*LW +: LW]),
            .dout(cln_b_d[l*LW +: LW])
        );
        fpx_elem u_elem (
            .dbl(res_dbl),
            .rc(ctrl_q[C_RC +: 2]),
            .ftz(ctrl_q[C_FTZ]),
            .mask(masks),
            .sgn(res_sign[l]),
            .uexp(res_exp[l*EW +: EW]),
            .mant(res_mant[l*LW +: LW]),
            .zero(res_zero[l]),
            .pre(res_pre[l*3 +: 3]),
            .y(lane_y[l*LW +: LW]),
            .fl(lane_fl[l*NF +: NF]),
            .trp(lane_trp[l])
        );
    end

    // OR flags and traps of enabled lanes
    always_comb begin
        acc_fl = '0;
        acc_trp = 1'b0;
        acc_y = '0;
        for (int l = 0; l < NL; l++) begin
            if (res_lane_en[l]) begin
                acc_fl = acc_fl | lane_fl[l*NF +: NF];
                acc_trp = acc_trp | lane_trp[l];
                acc_y[l*LW +: LW] = lane_y[l*LW +: LW];
            end
        end
    end

    // Cleaned operands go back to the arithmetic one cycle later
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cln_valid_q <= 1'b0;
            cln_a_q <= '0;
            cln_b_q <= '0;
        end else if (ce) begin
            cln_valid_q <= op_valid;
            if (op_valid) begin
                cln_a_q <= cln_a_d;
                cln_b_q <= cln_b_d;
            end
        end
    end
    assign cln_valid = cln_valid_q;
    assign cln_a = cln_a_q;
    assign cln_b = cln_b_q;

    // Result, flags and trap; result kept on trap for the handler
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            out_valid_q <= 1'b0;
            out_data_q <= '0;
            out_flags_q <= '0;
            trap_q <= 1'b0;
            trap_cause_q <= '0;
        end else if (ce) begin
            out_valid_q <= res_valid;
            trap_q <= res_valid && acc_trp;
            if (res_valid) begin
                out_data_q <= acc_y;
                out_flags_q <= acc_fl;
            end
            if (res_valid && acc_trp) begin
                trap_cause_q <= acc_fl & ~masks;
            end
        end
    end
    assign out_valid = out_valid_q;
    assign out_data = out_data_q;
    assign out_flags = out_flags_q;
    assign trap = trap_q;
    assign trap_cause = trap_cause_q;

    // Helpers for lane-0 checks below
    logic l0_ok;
    logic signed [EW-1:0] e0;
    assign l0_ok = ce && res_valid && res_lane_en == 2'h1 && res_pre[2:0] == 3'h0 && !res_zero[0];
    assign e0 = res_exp[EW-1:0];

    a_sticky_hold: assert property (
        @(posedge mclk) disable iff (!rst_n)
        ce && !(wr_en && sel[1]) |=> (status_q & $past(status_q)) == $past(status_q))
        else $error("status flag dropped without a clear");

    a_flag_accum: assert property (
        @(posedge mclk) disable iff (!rst_n)
        ce && res_valid |=> (status_q & $past(acc_fl)) == $past(acc_fl) && trap == $past(acc_trp))
        else $error("lane flags not accumulated");

    a_daz_clear: assert property (
        @(posedge mclk) disable iff (!rst_n)
        ce && op_valid && !op_dbl && ctrl_q[C_DAZ] && op_a[30:23] == 8'h00
        |=> cln_a[30:0] == 31'h0 && cln_a[31] == $past(op_a[31]))
        else $error("denormal operand not replaced by zero");

    a_dz_no_den: assert property (
        @(posedge mclk) disable iff (!rst_n)
        ce && res_valid && res_lane_en == 2'h1 && res_pre[F_ZE] |=> !out_flags[F_DE])
        else $error("denormal flag kept with divide by zero");

    a_fault_first: assert property (
        @(posedge mclk) disable iff (!rst_n)
        ce && res_valid && res_lane_en == 2'h1 && res_pre[F_IE] && !masks[F_IE]
        |=> trap && out_flags[F_PE:F_OE] == 3'h0 && trap_cause[F_IE])
        else $error("post-computation flags after unmasked fault");

    a_sp_scale: assert property (
        @(posedge mclk) disable iff (!rst_n)
        l0_ok && !res_dbl && !masks[F_UE] && e0 < -16'sh0080 && res_mant[39:0] == 40'h0
        |=> trap && out_flags[F_UE] && !out_flags[F_PE]
            && out_data[30:23] == 8'($past(e0) + 16'sh013f))
        else $error("single underflow result not scaled");

    a_dp_scale: assert property (
        @(posedge mclk) disable iff (!rst_n)
        l0_ok && res_dbl && !masks[F_UE] && e0 < -16'sh03fe && res_mant[10:0] == 11'h0
        |=> trap && out_flags[F_UE] && out_data[62:52] == 11'($past(e0) + 16'sh09ff))
        else $error("double underflow result not scaled");

    a_ftz_flush: assert property (
        @(posedge mclk) disable iff (!rst_n)
        l0_ok && !res_dbl && masks[F_UE] && ctrl_q[C_FTZ] && e0 < -16'sh007f
        |=> out_data[30:0] == 31'h0 && out_flags[F_UE] && out_flags[F_PE])
        else $error("tiny result not flushed to zero");

    a_den_exact: assert property (
        @(posedge mclk) disable iff (!rst_n)
        l0_ok && !res_dbl && masks[F_UE] && !ctrl_q[C_FTZ] && e0 == -16'sh007f
            && res_mant[40:0] == 41'h0
        |=> !out_flags[F_UE] && out_data[30:23] == 8'h00
            && out_data[22:0] == $past(res_mant[63:41]))
        else $error("exact denormal result wrong");

    a_inexact_set: assert property (
        @(posedge mclk) disable iff (!rst_n)
        l0_ok && !res_dbl && e0 == 16'sh0000 && res_mant[39:0] != 40'h0
        |=> out_flags[F_PE] && trap == !$past(masks[F_PE]))
        else $error("inexact result not flagged");
endmodule

//--- dv/tb.sv
// Self-checking bench for the FP underflow/inexact exception unit
`timescale 1ns/1ps
module tb;
    import fpx_pkg::*;
    localparam logic [63:0] M1 = 64'h8000_0000_0000_0000;
    localparam logic [63:0] MS = 64'h8000_0000_0000_0001;
    localparam logic [127:0] ONE = 128'h3f80_0000;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic op_valid = 1'b0;
    logic op_dbl = 1'b0;
    logic [127:0] op_a = 128'h0;
    logic [127:0] op_b = 128'h0;
    logic res_valid = 1'b0;
    logic res_dbl = 1'b0;
    logic [1:0] res_lane_en = 2'h0;
    logic [1:0] res_sign = 2'h0;
    logic [31:0] res_exp = 32'h0;
    logic [127:0] res_mant = 128'h0;
    logic [5:0] res_pre = 6'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, cln_valid, out_valid, trap, irq, er;
    logic [127:0] cln_a, cln_b, out_data;
    logic [5:0] out_flags, trap_cause;
    logic [140:0] rq[$];
    logic [255:0] cq[$];
    logic [140:0] x;
    logic [255:0] y;
    logic [1:0] sg;
    logic [1:0] zr = 2'b00;
    int error_cnt = 0;
    int check_count = 0;

    // Free-running 100 MHz clock
    always #5 mclk = ~mclk;

    fpx_core DUT (.mclk(mclk), .nrst(nrst), .ce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .op_valid(op_valid), .op_dbl(op_dbl), .op_a(op_a), .op_b(op_b),
        .cln_valid(cln_valid), .cln_a(cln_a), .cln_b(cln_b), .res_valid(res_valid),
        .res_dbl(res_dbl), .res_lane_en(res_lane_en), .res_sign(res_sign), .res_exp(res_exp),
        .res_mant(res_mant), .res_zero(zr), .res_pre(res_pre), .out_valid(out_valid),
        .out_data(out_data), .out_flags(out_flags), .trap(trap), .trap_cause(trap_cause),
        .irq(irq));

    task chk(input string nm, input logic [127:0] e, input logic [127:0] g);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task conclude;
        if (error_cnt == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // One APB transfer; answer taken at the edge where pready is seen high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge mclk);
            n++;
        end
        if (n == 20) error_cnt++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge keeps the next request out of this time step
        @(posedge mclk);
    endtask

    task rchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk("prdata", 128'(e), 128'(rd));
    endtask

    // Present one result; expectation noted for the watcher
    task put(input logic d, input logic [1:0] en, input logic [31:0] e, input logic [127:0] m,
        input logic [5:0] pr, input logic [127:0] xd, input logic [5:0] xf,
        input logic [6:0] xt);
        res_valid <= 1'b1;
        res_dbl <= d;
        res_lane_en <= en;
        res_sign <= sg;
        res_exp <= e;
        res_mant <= m;
        res_pre <= pr;
        rq.push_back({xd, xf, xt});
        @(posedge mclk);
        res_valid <= 1'b0;
        @(posedge mclk);
    endtask

    // Watcher: each result pulse is matched against the oldest note
    always @(posedge mclk) begin
        if (out_valid === 1'b1) begin
            x = rq.pop_front();
            chk("out_data", x[140:13], out_data);
            chk("out_flags", 128'(x[12:7]), 128'(out_flags));
            chk("trap", 128'(x[6]), 128'(trap));
            if (x[6]) chk("trap_cause", 128'(x[5:0]), 128'(trap_cause));
        end
        if (cln_valid === 1'b1) begin
            y = cq.pop_front();
            chk("cln_a", y[255:128], cln_a);
            chk("cln_b", y[127:0], cln_b);
        end
    end

    // Watchdog sized well beyond the expected run
    initial begin
        #200000;
        error_cnt++;
        conclude;
    end

    initial begin
        void'($urandom(75720));
        sg = 2'b00;
        repeat (12) @(posedge mclk);
        nrst <= 1'b1;
        repeat (3) @(posedge mclk);
        rchk(A_CTRL, 32'h3f);
        rchk(A_STAT, 32'h0);
        put(0, 2'b01, 32'h0, {64'h0, MS}, 6'h0, ONE, 6'h20, 7'h0);
        put(0, 2'b01, 32'h0, {64'h0, M1}, 6'h0, ONE, 6'h00, 7'h0);
        rchk(A_STAT, 32'h20);
        chk("irq", 128'h0, 128'(irq));
        apb(1'b1, A_IREN, 32'h20);
        chk("irq", 128'h1, 128'(irq));
        apb(1'b1, A_STAT, 32'h20);
        chk("irq", 128'h0, 128'(irq));
        rchk(A_STAT, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        chk("pslverr", 128'h1, 128'(er));
        // Every rounding mode with a random sign on an inexact value
        for (int r = 0; r < 4; r++) begin
            apb(1'b1, A_CTRL, 32'h3f | (r << 6));
            sg = 2'($urandom % 2);
            put(0, 2'b01, 32'h0, {64'h0, MS}, 6'h0, {96'h0, sg[0], 31'h3f80_0000} +
                128'((r == 2 && !sg[0]) || (r == 1 && sg[0])), 6'h20, 7'h0);
        end
        sg = 2'b00;
        apb(1'b1, A_CTRL, 32'h3f);
        put(0, 2'b01, 32'hff82, {64'h0, M1}, 6'h0, 128'h80_0000, 6'h00, 7'h0);
        put(0, 2'b01, 32'hff81, {64'h0, M1}, 6'h0, 128'h40_0000, 6'h00, 7'h0);
        put(0, 2'b01, 32'hff81, 128'h8000_02ff_ffff_f000, 6'h0, 128'h40_0001, 6'h30,
            7'h0);
        put(1, 2'b01, 32'hfc01, {64'h0, M1}, 6'h0, 128'h8_0000_0000_0000, 6'h0, 7'h0);
        put(0, 2'b11, 32'hff81_0000, {MS, M1}, 6'h0, {64'h40_0000, ONE[63:0]}, 6'h30,
            7'h0);
        put(0, 2'b01, 32'h0, {64'h0, M1}, 6'h6, ONE, 6'h04, 7'h0);
        // Exact zero lane delivers a zero with no flags
        zr <= 2'b01;
        put(0, 2'b01, 32'h0, {64'h0, M1}, 6'h0, 128'h0, 6'h00, 7'h0);
        zr <= 2'b00;
        // Underflow unmasked: scaled results and traps
        apb(1'b1, A_CTRL, 32'h2f);
        put(0, 2'b01, 32'hff7e, {64'h0, M1}, 6'h0, 128'h5e80_0000, 6'h10, 7'h50);
        put(0, 2'b01, 32'hff7e, {64'h0, MS}, 6'h0, 128'h5e80_0000, 6'h30, 7'h50);
        put(1, 2'b01, 32'hfc01, {64'h0, M1}, 6'h0, 128'h6000_0000_0000_0000, 6'h10,
            7'h50);
        put(0, 2'b11, 32'hff7e_0000, {M1, M1}, 6'h0, {64'h5e80_0000, ONE[63:0]}, 6'h10,
            7'h50);
        rchk(A_TRAP, 32'h10);
        // Inexact unmasked, with and without a masked underflow; then flush to zero and an unmasked invalid fault
        apb(1'b1, A_CTRL, 32'h1f);
        put(0, 2'b01, 32'h0, {64'h0, MS}, 6'h0, ONE, 6'h20, 7'h60);
        put(0, 2'b01, 32'hff81, {64'h0, MS}, 6'h0, 128'h40_0000, 6'h30, 7'h60);
        apb(1'b1, A_CTRL, 32'h23f);
        put(0, 2'b01, 32'hff80, {64'h0, MS}, 6'h0, 128'h0, 6'h30, 7'h0);
        apb(1'b1, A_CTRL, 32'h3e);
        put(0, 2'b01, 32'hff81, {64'h0, MS}, 6'h1, 128'h0, 6'h01, 7'h41);
        // Operand cleaning with the zeroing mode off and on
        for (int d = 0; d < 2; d++) begin
            apb(1'b1, A_CTRL, 32'h3f | (d << 8));
            op_a <= {64'h3f80_0000, 64'h8000_0001};
            op_b <= 128'h1;
            op_valid <= 1'b1;
            cq.push_back({64'h3f80_0000, d ? 64'h8000_0000 : 64'h8000_0001,
                d ? 128'h0 : 128'h1});
            @(posedge mclk);
            op_valid <= 1'b0;
            @(posedge mclk);
        end
        repeat (4) @(posedge mclk);
        chk("pending", 128'h0, 128'(rq.size() + cq.size()));
        conclude;
    end
endmodule
